// ### alu8.sv
/*
  Eight-bit adder with the five status flags. Subtraction is done as the
  addition of the inverted subtrahend with carry in set.
  Assumes purely combinational use by the execution core.
*/
`timescale 1ns/10ps
module alu8 (
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire exec_pkg::alu_op_type op,
  output exec_pkg::alu_out_type result
);
  import exec_pkg::*;

  logic [7:0] addend;
  logic carryIn;
  logic [8:0] full;
  logic [4:0] low;

  // Two's complement subtract: carry is the inverted borrow. [RULE10]
  always_comb begin
    addend = (op == OP_SUB) ? ~opB : opB;
    carryIn = (op == OP_SUB);
    full = {1'b0, opA} + {1'b0, addend} + {8'h00, carryIn};
    low = {1'b0, opA[3:0]} + {1'b0, addend[3:0]} + {4'h0, carryIn};
    result.sum = full[7:0];
    result.flags = '0;
    result.flags[FLAG_CARRY] = full[8]; // [RULE9]
    result.flags[FLAG_HALF] = low[4];
    result.flags[FLAG_ZERO] = (full[7:0] == 8'h00); // [RULE9]
    result.flags[FLAG_NEG] = full[7];
    result.flags[FLAG_WRAP] = (opA[7] == addend[7]) &&
                              (full[7] != opA[7]);
  end

endmodule : alu8

// ### arith_bit_branch_exec.sv
/*
  Execution core for a subset of an eight-bit instruction set: add literal,
  add to file, bit clear, branch if minus and literal minus accumulator.
  Each instruction runs in four phases of the core clock, a taken branch in eight. Assumes a data
  memory that answers a read in the same cycle (combinational rdata) and an
  instruction source that holds instrWord stable while instrValid is high.
*/
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// [RULE1] Add literal to accumulator, update five flags.
// [RULE2] Add accumulator to file, destination bit selects target.
// [RULE3] Bank bit zero access bank, one pointer.
// [RULE4] Extended mode, low addresses use indexed offset.
// [RULE5] Bit clear zeroes one bit, no flags.
// [RULE6] Taken branch adds twice offset to counter.
// [RULE7] Taken branch two cycles, untaken one cycle.
// [RULE8] Literal minus accumulator, result to accumulator.
// [RULE9] Carry set when nonnegative, zero when equal.
// [RULE10] Two's complement, carry is inverted borrow.
// [RULE11] Four phases: decode, read, process, write.
module arith_bit_branch_exec (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [15:0] instrWord,
  input wire logic instrValid,
  output logic instrTaken,
  input wire logic [3:0] bank_pointer,
  input wire logic extendedEnable,
  input wire logic [11:0] indexBase,
  output exec_pkg::mem_req_type memReq,
  input wire logic [7:0] memRdata,
  output logic [7:0] accumulator,
  output logic [4:0] statusFlags,
  output logic [20:0] program_counter,
  output logic illegalOp
);
  import exec_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  // File address resolution is shared by every file-register instruction.
  function automatic logic [11:0] resolveAddr(input logic [15:0] w,
      input logic [3:0] bp, input logic ext, input logic [11:0] base);
    logic [11:0] a;
    a = 12'h000;
    if (w[BANK_BIT]) begin
      a = {bp, w[7:0]}; // [RULE3]
    end else if (ext && (w[7:0] <= INDEXED_LIMIT)) begin
      a = base + {4'h0, w[7:0]}; // [RULE4]
    end else if (w[7:0] < ACCESS_SPLIT) begin
      a = {4'h0, w[7:0]}; // [RULE3]
    end else begin
      a = {ACCESS_HIGH_BANK, w[7:0]};
    end
    return a;
  endfunction : resolveAddr

  //////////////////////////////////////////////////////////////////////////
  // State.

  phase_type phase, next_phase;
  logic [15:0] instr, next_instr;
  logic [7:0] operand, next_operand;
  logic [7:0] result, next_result;
  logic [4:0] flagsNew, next_flagsNew;
  logic [11:0] addr, next_addr;
  logic branchStall, next_branchStall;
  logic [7:0] next_accumulator;
  logic [4:0] next_statusFlags;
  logic [20:0] next_program_counter;
  logic next_illegalOp;
  mem_req_type next_memReq;

  logic isAddLit, isAddFile, isBitClr, isBranch, isSubLit;
  logic [7:0] aluA, aluB;
  alu_op_type aluOp;
  alu_out_type aluRes;
  logic [7:0] clearMask;
  logic [20:0] offset;

  // Opcode classes of the latched instruction.
  assign isAddLit = (instr[15:8] == OPC_ADD_LITERAL); // [RULE1]
  assign isAddFile = (instr[15:10] == OPC_ADD_TO_FILE); // [RULE2]
  assign isBitClr = (instr[15:12] == OPC_BIT_CLEAR); // [RULE5]
  assign isBranch = (instr[15:8] == OPC_BRANCH_MINUS); // [RULE6]
  assign isSubLit = (instr[15:8] == OPC_LIT_MINUS_ACC); // [RULE8]

  // Only the decode phase of a fresh slot accepts a word.
  // A stalled slot refuses words so none is lost behind a branch.
  assign instrTaken = (phase == PH_DECODE) && !branchStall && instrValid;

  alu8 u_alu (
    .opA(aluA),
    .opB(aluB),
    .op(aluOp),
    .result(aluRes)
  );

  // Literal minus accumulator puts the literal on side A.
  always_comb begin
    aluOp = isSubLit ? OP_SUB : OP_ADD; // [RULE10]
    aluA = isSubLit ? operand : accumulator; // [RULE8]
    aluB = isSubLit ? accumulator : operand;
    clearMask = ~(8'h01 << instr[BITIDX_LSB +: 3]); // [RULE5]
    offset = {{12{instr[7]}}, instr[7:0], 1'b0}; // [RULE6]
  end

  //////////////////////////////////////////////////////////////////////////
  // Phase sequencer and datapath, one phase per clock.

  always_comb begin
    next_phase = phase;
    next_instr = instr;
    next_operand = operand;
    next_result = result;
    next_flagsNew = flagsNew;
    next_addr = addr;
    next_branchStall = branchStall;
    next_accumulator = accumulator;
    next_statusFlags = statusFlags;
    next_program_counter = program_counter;
    next_illegalOp = 1'b0;
    next_memReq = '0;
    unique case (phase)
      PH_DECODE: begin
        // A taken branch spends a whole empty cycle here. [RULE7]
        if (branchStall) begin
          next_phase = PH_READ;
        end else if (instrValid) begin
          next_instr = instrWord;
          next_addr = resolveAddr(instrWord, bank_pointer,
                                  extendedEnable, indexBase);
          next_program_counter = program_counter + COUNTER_STEP;
          next_phase = PH_READ; // [RULE11]
        end
      end
      PH_READ: begin
        // Operand read: literal or file register. [RULE11]
        if (isAddFile || isBitClr) begin
          next_operand = memRdata;
        end else begin
          next_operand = instr[7:0];
        end
        next_phase = PH_PROCESS;
      end
      PH_PROCESS: begin
        // Bit clear bypasses the adder; its flags are dropped later.
        next_result = isBitClr ? (operand & clearMask) : aluRes.sum;
        next_flagsNew = aluRes.flags;
        next_phase = PH_WRITE; // [RULE11]
      end
      PH_WRITE: begin
        next_phase = PH_DECODE;
        if (branchStall) begin
          next_branchStall = 1'b0;
        end else if (isAddLit || isSubLit) begin
          next_accumulator = result; // [RULE1] [RULE8]
          next_statusFlags = flagsNew; // [RULE9]
        end else if (isAddFile) begin
          next_statusFlags = flagsNew; // [RULE2]
          if (instr[DEST_BIT]) begin
            next_memReq = '{addr: addr, wdata: result, write: 1'b1};
          end else begin
            next_accumulator = result;
          end
        end else if (isBitClr) begin
          // Flags untouched on purpose. [RULE5]
          next_memReq = '{addr: addr, wdata: result, write: 1'b1};
        end else if (isBranch) begin
          // Untaken branch leaves the counter alone. [RULE7]
          // The minus flag is the one the previous instruction left, since
          // a branch writes no flag and nothing else can change it here.
          if (statusFlags[FLAG_NEG]) begin
            next_program_counter = program_counter + offset; // [RULE6]
            next_branchStall = 1'b1; // [RULE7]
          end
        end else begin
          next_illegalOp = 1'b1;
        end
      end
    endcase
    // The read address is driven during the read phase.
    // Holding it between reads keeps memRdata steady for the next one.
    if (phase == PH_DECODE && !branchStall && instrValid) begin
      next_memReq.addr = next_addr;
    end else if (!next_memReq.write) begin
      next_memReq.addr = addr;
    end
  end

  // Registers only; all decisions above.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      phase <= PH_DECODE;
      instr <= 16'h0000;
      operand <= 8'h00;
      result <= 8'h00;
      flagsNew <= STATUS_RESET;
      addr <= 12'h000;
      branchStall <= 1'b0;
      accumulator <= ACC_RESET;
      statusFlags <= STATUS_RESET;
      program_counter <= COUNTER_RESET;
      illegalOp <= 1'b0;
      memReq <= '0;
    end else begin
      phase <= next_phase;
      instr <= next_instr;
      operand <= next_operand;
      result <= next_result;
      flagsNew <= next_flagsNew;
      addr <= next_addr;
      branchStall <= next_branchStall;
      accumulator <= next_accumulator;
      statusFlags <= next_statusFlags;
      program_counter <= next_program_counter;
      illegalOp <= next_illegalOp;
      memReq <= next_memReq;
    end
  end

endmodule : arith_bit_branch_exec

// ### exec_checker.sv
/*
  Port checker for the execution core, bound after the module.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module exec_checker (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [15:0] instrWord,
  input wire logic instrValid,
  input wire logic instrTaken,
  input wire logic [3:0] bank_pointer,
  input wire logic extendedEnable,
  input wire logic [11:0] indexBase,
  input wire exec_pkg::mem_req_type memReq,
  input wire logic [7:0] memRdata,
  input wire logic [7:0] accumulator,
  input wire logic [4:0] statusFlags,
  input wire logic [20:0] program_counter,
  input wire logic illegalOp
);
  import exec_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // Operands are read one edge late, so they follow the previous result.
  sequence s_op(logic [7:0] c);
    instrTaken && instrWord[15:8] == c;
  endsequence
  sequence s_addf;
    instrTaken && instrWord[15:10] == OPC_ADD_TO_FILE;
  endsequence
  sequence s_jump;
    s_op(OPC_BRANCH_MINUS) ##1 statusFlags[FLAG_NEG];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_ADD_LIT: assert property (s_op(OPC_ADD_LITERAL) |-> ##4
    accumulator == $past(accumulator, 3) + $past(instrWord[7:0], 4))
    else $error("add literal sum");
  AST_SUB_FLAGS: assert property (s_op(OPC_LIT_MINUS_ACC)
    |-> ##4 statusFlags[FLAG_CARRY] == ($past(instrWord[7:0], 4) >=
    $past(accumulator, 3)) && statusFlags[FLAG_ZERO] ==
    ($past(instrWord[7:0], 4) == $past(accumulator, 3)))
    else $error("subtract flags");
  AST_DEST: assert property (s_addf |-> ##4
    memReq.write == $past(instrWord[DEST_BIT], 4))
    else $error("destination select");
  AST_BANK: assert property (s_addf ##0 instrWord[BANK_BIT] |=>
    memReq.addr == {$past(bank_pointer), $past(instrWord[7:0])})
    else $error("bank pointer address");
  AST_INDEXED: assert property (s_addf ##0 (!instrWord[BANK_BIT] &&
    extendedEnable && instrWord[7:0] <= INDEXED_LIMIT) |=>
    memReq.addr == $past(indexBase) + $past(instrWord[7:0]))
    else $error("indexed address");
  AST_CLEAR: assert property (instrTaken &&
    instrWord[15:12] == OPC_BIT_CLEAR |-> ##4 memReq.write &&
    !memReq.wdata[$past(instrWord[11:9], 4)] &&
    statusFlags == $past(statusFlags, 3))
    else $error("bit clear");
  AST_TARGET: assert property (s_jump |-> ##3 program_counter ==
    $past(program_counter, 3) + {{12{$past(instrWord[7], 4)}},
    $past(instrWord[7:0], 4), 1'h0})
    else $error("branch target");
  AST_STALL: assert property (s_jump |=> !instrTaken [*6])
    else $error("branch stall");
endmodule : exec_checker

bind arith_bit_branch_exec exec_checker u_exec_checker (.*);

// ### exec_pkg.sv
/*
  Shared constants and types for the arithmetic, bit and branch execution
  block: opcode patterns, field positions, phase enumeration, flag layout.
  Assumes it is compiled before every module that imports it.
*/
package exec_pkg;

  // Opcode patterns of the decoded subset.
  localparam logic [7:0] OPC_ADD_LITERAL = 8'h0f;
  localparam logic [5:0] OPC_ADD_TO_FILE = 6'h09;
  localparam logic [3:0] OPC_BIT_CLEAR = 4'h9;
  localparam logic [7:0] OPC_BRANCH_MINUS = 8'he6;
  localparam logic [7:0] OPC_LIT_MINUS_ACC = 8'h08;

  // Field positions inside an instruction word.
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam int BITIDX_LSB = 9;

  // Highest address field that still selects indexed literal-offset addressing.
  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  // Access bank: addresses below 0x60 map to bank 0, the rest to bank 15.
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

  // Flag positions in the status word.
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_HALF = 1;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_WRAP = 3;
  localparam int FLAG_NEG = 4;

  // Reset values and the counter step.
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  localparam logic [20:0] COUNTER_RESET = 21'h00_0000;
  localparam logic [20:0] COUNTER_STEP = 21'h00_0002;

  typedef enum logic [1:0] {
    OP_ADD,
    OP_SUB
  } alu_op_type;

  typedef enum {
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } phase_type;

  // Result of one arithmetic step.
  typedef struct packed {
    logic [7:0] sum;
    logic [4:0] flags;
  } alu_out_type;

  // Data-memory request produced by the core.
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic write;
  } mem_req_type;

endpackage : exec_pkg

// ### tb_arith_bit_branch_exec.sv
/*
  Self-checking bench for the execution core with a reference model.
  Assumes exec_pkg, the core and its checker are compiled first.
*/
`timescale 1ns/10ps
module tb_arith_bit_branch_exec;
  import exec_pkg::*;
  logic clk_sys = 1'h0;
  logic rstn = 1'h0;
  logic instrValid = 1'h0;
  logic extendedEnable = 1'h0;
  logic [15:0] instrWord = 16'h0000;
  logic [3:0] bank_pointer = 4'h0;
  logic [11:0] indexBase = 12'h000;
  logic instrTaken, illegalOp;
  logic [7:0] memRdata, accumulator;
  logic [4:0] statusFlags;
  logic [20:0] program_counter;
  mem_req_type memReq;
  logic [7:0] mem [4096];
  logic [31:0] seed = 32'h0000_8473;
  int mismatches = 0, tests_run = 0, w = 0, fl = 0, progCount = 0;
  // Model expectations, queued in the order the checks consume them.
  logic [39:0] expq[$];

  arith_bit_branch_exec u_arith_bit_branch_exec (.*);

  // Data memory answers at once and takes the one-cycle write pulse.
  assign memRdata = mem[memReq.addr];
  always @(posedge clk_sys)
    if (memReq.write === 1'h1) mem[memReq.addr] <= memReq.wdata;
  initial forever #25 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Sum in bits 7..0, then carry, half carry, zero, wrap, negative.
  function automatic int alu(int x, int y, int ci);
    int s;
    s = x + y + ci;
    return (s & 'h1ff) | ((((x & 15) + (y & 15) + ci) >> 4) << 9) |
      (((s & 255) == 0) << 10) | ((((x ^ s) & (y ^ s) & 128) != 0) << 11) |
      ((s & 128) << 5);
  endfunction : alu

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One word end to end; valid stays up so early takes are caught.
  task automatic run(input logic [15:0] iw);
    int r, n, gap, ill, il, adr, f, k, fo, wr;
    logic [7:0] m;
    logic [39:0] g;
    instrWord = iw;
    instrValid = 1'h1;
    {n, il, r, f} = {32'd0, 32'd0, -32'd1, 24'd0, iw[7:0]};
    fo = iw[15:10] == OPC_ADD_TO_FILE || iw[15:12] == OPC_BIT_CLEAR;
    ill = !fo && !(iw[15:8] inside
      {OPC_ADD_LITERAL, OPC_LIT_MINUS_ACC, OPC_BRANCH_MINUS});
    wr = fo && !(iw[15:10] == OPC_ADD_TO_FILE && !iw[DEST_BIT]);
    adr = iw[BANK_BIT] ? {bank_pointer, iw[7:0]} :
      extendedEnable && f <= INDEXED_LIMIT ? (indexBase + f) & 'hfff :
      f < ACCESS_SPLIT ? f : {ACCESS_HIGH_BANK, iw[7:0]};
    m = mem[adr];
    gap = iw[15:8] == OPC_BRANCH_MINUS && fl[FLAG_NEG] ? 8 : 4;
    if (iw[15:8] == OPC_ADD_LITERAL) r = alu(w, f, 0);
    else if (iw[15:8] == OPC_LIT_MINUS_ACC) r = alu(f, 255 - w, 1);
    else if (iw[15:10] == OPC_ADD_TO_FILE) r = alu(w, m, 0);
    else if (fo) m[iw[11:9]] = 1'h0;
    if (r >= 0) fl = r >> 8;
    if (r >= 0 && wr) m = r[7:0];
    else if (r >= 0) w = r & 255;
    progCount = progCount + 2;
    expq.push_back(40'(progCount[20:0]));
    if (gap == 8) progCount = progCount + 2 * $signed(iw[7:0]);
    expq.push_back(40'({w[7:0], fl[4:0], progCount[20:0]}));
    expq.push_back(40'({wr[0], wr ? m : 8'h00}));
    @(negedge clk_sys);
    while (instrTaken !== 1'h1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n, 0);
    @(posedge clk_sys);
    #1;
    for (k = 1; k <= gap; k++) begin
      @(negedge clk_sys);
      il += illegalOp === 1'h1;
      if (k < gap) chk(instrTaken, 0);
      if (k == 1) chk(program_counter, expq.pop_front());
      if (k == 1 && fo) chk(memReq.addr, adr);
      if (k == 4) g = 40'({accumulator, statusFlags, program_counter});
      if (k == 4) chk(g, expq.pop_front());
      if (k == 4) g = 40'({memReq.write, wr ? memReq.wdata : 8'h00});
      if (k == 4) chk(g, expq.pop_front());
      @(posedge clk_sys);
      #1;
      if (k == gap - 1) instrValid = 1'h0;
    end
    chk(il, ill);
  endtask : run

  task automatic conclude();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////
  // The watchdog allows several times the expected run length.
  initial begin
    #500000;
    mismatches++;
    conclude();
  end

  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'(rnd());
    repeat (8) @(posedge clk_sys);
    #1;
    rstn = 1'h1;
    chk({accumulator, statusFlags, program_counter}, 0);
    // A nonzero base tells indexed from access-bank addressing apart.
    indexBase = 12'h0a0;
    for (int i = 0; i < 4; i++) begin
      extendedEnable = i[1];
      run({OPC_ADD_TO_FILE, 2'h2, 8'h5f + 8'(i[0])});
    end
    for (int i = 0; i < 25; i++) begin
      bank_pointer = 4'(rnd());
      indexBase = 12'(rnd());
      extendedEnable = 1'(rnd());
      run({OPC_ADD_LITERAL, 8'(rnd())});
      run({OPC_LIT_MINUS_ACC, 8'(rnd())});
      run({OPC_ADD_TO_FILE, 10'(rnd())});
      run({OPC_BIT_CLEAR, 12'(rnd())});
      run({OPC_BRANCH_MINUS, 8'(rnd())});
    end
    run({OPC_LIT_MINUS_ACC, 8'(w)});
    run({OPC_ADD_LITERAL, 8'h01});
    run({OPC_LIT_MINUS_ACC, 8'h00});
    run({OPC_BRANCH_MINUS, 8'h80});
    run({OPC_BRANCH_MINUS, 8'h7f});
    run(16'hffff);
    conclude();
  end
endmodule : tb_arith_bit_branch_exec
